// ---- rtl/panel_pkg.sv ----
// panel_pkg: shared constants and carrier types for the panel pixel input port
// assumes: single 50 MHz system clock, synchronous active-high reset
package panel_pkg;

  // ----------------------------------------
  // pixel format and active area
  // ----------------------------------------
  localparam int COMP_W = 6;
  localparam int PIX_W = 3 * COMP_W;
  localparam int ACTIVE_COLS = 320;
  localparam int ACTIVE_LINES = 240;
  localparam int COL_W = 9;
  localparam int LINE_W = 8;

  // ----------------------------------------
  // line and frame placement; the fixed line start is used when the strobe is held low
  // ----------------------------------------
  localparam int FIXED_H_START = 72;
  localparam int V_START = 6;
  localparam int H_CNT_W = 10;
  localparam int V_CNT_W = 9;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
  } pixel_t;

  typedef struct packed {
    logic hSync;
    logic vSync;
    logic lineDataEnable;
    logic scanInvertSelect;
    pixel_t pix;
  } pin_sample_t;

  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [LINE_W-1:0] row;
    logic frameStart;
    pixel_t pix;
  } pixel_word_t;

endpackage

// ---- rtl/rgb_panel_input_port.sv ----
// rgb_panel_input_port: samples the parallel rgb video pins and emits placed pixels
// assumes: pins come from another clock domain and are oversampled on clock;
// the pixel sampling clock arrives as an ordinary pin input
//
// How it works
// - each pixel is three 6-bit components red, green, blue, bit 5 most significant.
// - the active area is 320 columns by 240 lines of rgb stripe pixels.
// - data, syncs and enable are captured on rising edges of the pixel clock, one pixel per edge.
// - with the strobe in use, a line starts at the pixel clock where the strobe rises.
// - with the strobe held low, a line starts a fixed count of pixel clocks after line sync rises.
// - scan select low gives normal orientation, high mirrors both horizontally and vertically.
// - the pixel sampled with the strobe rising edge lands in column 0, or in the last column when scan select is high.
// - the strobe has no effect on vertical placement; only vertical sync sets the first line.
`timescale 1ns/1ps

module rgb_panel_input_port
  import panel_pkg::*;
#(
  parameter int COLS = ACTIVE_COLS,
  parameter int LINES = ACTIVE_LINES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pixelClockPin,
  input wire logic hSyncPin,
  input wire logic vSyncPin,
  input wire logic lineDataEnablePin,
  input wire logic scanInvertSelectPin,
  input wire logic [COMP_W-1:0] redComponent,
  input wire logic [COMP_W-1:0] greenComponent,
  input wire logic [COMP_W-1:0] blueComponent,
  output logic pixelValid,
  input wire logic pixelReady,
  output pixel_word_t pixelWord,
  output logic overflow
);

  // refuse geometries that the counters and the end-of-line compare cannot serve
  if (COLS > ACTIVE_COLS || LINES > ACTIVE_LINES || COLS < 2 || LINES < 1) begin : g_bad_geometry
    $error("panel geometry exceeds counter widths");
  end

  // ----------------------------------------
  // pin synchroniser: three stages, change taken when stages two and three agree
  // ----------------------------------------
  localparam int SW = PIX_W + 5;
  logic [SW-1:0] pinBus;
  logic [SW-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
  logic [SW-1:0] s1_next, s2_next, s3_next, stable_next;

  assign pinBus = {pixelClockPin, hSyncPin, vSyncPin, lineDataEnablePin, scanInvertSelectPin,
                   redComponent, greenComponent, blueComponent};

  always_comb begin
    s1_next = pinBus;
    s2_next = s1_reg;
    s3_next = s2_reg;
    stable_next = stable_reg;
    for (int i = 0; i < SW; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      stable_reg <= stable_next;
    end
  end

  // ----------------------------------------
  // capture on pixel clock rising edge
  // ----------------------------------------
  logic pclkPrev_reg, pclkPrev_next;
  logic pclkRise;
  pin_sample_t smp;

  // data is sampled with the same oversampled clock edge, so setup/hold at the pins carries over
  assign pclkRise = stable_reg[SW-1] && !pclkPrev_reg;
  assign smp.hSync = stable_reg[SW-2];
  assign smp.vSync = stable_reg[SW-3];
  assign smp.lineDataEnable = stable_reg[SW-4];
  assign smp.scanInvertSelect = stable_reg[SW-5];
  assign smp.pix = pixel_t'(stable_reg[PIX_W-1:0]);

  // ----------------------------------------
  // horizontal and vertical placement
  // ----------------------------------------
  logic hPrev_reg, hPrev_next, vPrev_reg, vPrev_next, dePrev_reg, dePrev_next;
  logic deSeen_reg, deSeen_next;
  logic [H_CNT_W-1:0] hCnt_reg, hCnt_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic lineActive_reg, lineActive_next;
  logic [V_CNT_W-1:0] vCnt_reg, vCnt_next;
  logic frameStartPend_reg, frameStartPend_next;
  logic pushValid;
  pixel_word_t pushWord;
  logic pushReady;
  logic hRise, vRise, deRise, vActive;
  logic [LINE_W-1:0] rowIdx;

  function automatic logic [COL_W-1:0] mirror_col(input logic [COL_W-1:0] c, input logic inv);
    mirror_col = inv ? COL_W'(COLS - 1) - c : c;
  endfunction

  function automatic logic [LINE_W-1:0] mirror_row(input logic [LINE_W-1:0] r, input logic inv);
    mirror_row = inv ? LINE_W'(LINES - 1) - r : r;
  endfunction

  assign hRise = smp.hSync && !hPrev_reg;
  assign vRise = smp.vSync && !vPrev_reg;
  assign deRise = smp.lineDataEnable && !dePrev_reg;
  // first active line counted only from vertical sync, strobe ignored here
  assign vActive = (vCnt_reg >= V_CNT_W'(V_START)) && (vCnt_reg < V_CNT_W'(V_START + LINES));
  assign rowIdx = LINE_W'(vCnt_reg - V_CNT_W'(V_START));

  always_comb begin
    pclkPrev_next = stable_reg[SW-1];
    hPrev_next = hPrev_reg;
    vPrev_next = vPrev_reg;
    dePrev_next = dePrev_reg;
    deSeen_next = deSeen_reg;
    hCnt_next = hCnt_reg;
    col_next = col_reg;
    lineActive_next = lineActive_reg;
    vCnt_next = vCnt_reg;
    frameStartPend_next = frameStartPend_reg;
    pushValid = 1'b0;
    pushWord = '0;
    if (pclkRise) begin
      hPrev_next = smp.hSync;
      vPrev_next = smp.vSync;
      dePrev_next = smp.lineDataEnable;
      if (hCnt_reg != '1) begin
        hCnt_next = hCnt_reg + 1'b1;
      end
      if (vRise) begin
        vCnt_next = '0;
        frameStartPend_next = 1'b1;
        deSeen_next = 1'b0;
      end else if (hRise && vCnt_reg != '1) begin
        vCnt_next = vCnt_reg + 1'b1;
      end
      if (hRise) begin
        hCnt_next = '0;
        lineActive_next = 1'b0;
      end
      // a strobe stuck high never rises, so that line simply shows nothing
      if (deRise) begin
        deSeen_next = 1'b1;
      end
      if ((deRise && vActive) ||
          (!deSeen_reg && !smp.lineDataEnable && !hRise && vActive &&
           hCnt_reg == H_CNT_W'(FIXED_H_START - 1))) begin
        lineActive_next = 1'b1;
        col_next = '0;
        pushValid = 1'b1;
        pushWord.col = mirror_col('0, smp.scanInvertSelect);
      end else if (lineActive_reg && !hRise) begin
        pushValid = 1'b1;
        pushWord.col = mirror_col(col_reg + 1'b1, smp.scanInvertSelect);
        col_next = col_reg + 1'b1;
        if (col_reg + 1'b1 == COL_W'(COLS - 1)) begin
          lineActive_next = 1'b0;
        end
      end
      if (pushValid) begin
        pushWord.row = mirror_row(rowIdx, smp.scanInvertSelect);
        pushWord.pix = smp.pix;
        pushWord.frameStart = frameStartPend_reg && (rowIdx == '0) &&
                              (pushWord.col == mirror_col('0, smp.scanInvertSelect));
        if (pushReady) begin
          frameStartPend_next = pushWord.frameStart ? 1'b0 : frameStartPend_reg;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pclkPrev_reg <= 1'b0;
      hPrev_reg <= 1'b0;
      vPrev_reg <= 1'b0;
      dePrev_reg <= 1'b0;
      deSeen_reg <= 1'b0;
      hCnt_reg <= '1;
      col_reg <= '0;
      lineActive_reg <= 1'b0;
      vCnt_reg <= '1;
      frameStartPend_reg <= 1'b0;
    end else begin
      pclkPrev_reg <= pclkPrev_next;
      hPrev_reg <= hPrev_next;
      vPrev_reg <= vPrev_next;
      dePrev_reg <= dePrev_next;
      deSeen_reg <= deSeen_next;
      hCnt_reg <= hCnt_next;
      col_reg <= col_next;
      lineActive_reg <= lineActive_next;
      vCnt_reg <= vCnt_next;
      frameStartPend_reg <= frameStartPend_next;
    end
  end

  // ----------------------------------------
  // two-entry skid buffer toward the pixel sink
  // ----------------------------------------
  pixel_word_t buf_reg [2];
  pixel_word_t buf_next [2];
  logic [1:0] count_reg, count_next;
  logic overflow_reg, overflow_next;

  // the video source cannot stall, so a word pushed while full is dropped and flagged;
  // a pop in the same cycle frees a slot, so only a stalled full buffer refuses
  assign pushReady = (count_reg != 2'd2) || pixelReady;

  always_comb begin
    buf_next = buf_reg;
    count_next = count_reg;
    overflow_next = overflow_reg;
    if (pixelValid && pixelReady) begin
      buf_next[0] = buf_reg[1];
      count_next = count_next - 2'd1;
    end
    if (pushValid) begin
      if (pushReady) begin
        buf_next[count_next[0]] = pushWord;
        count_next = count_next + 2'd1;
      end else begin
        overflow_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      count_reg <= '0;
      overflow_reg <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      count_reg <= count_next;
      overflow_reg <= overflow_next;
    end
  end

  assign pixelValid = (count_reg != 2'd0);
  assign pixelWord = buf_reg[0];
  assign overflow = overflow_reg;

endmodule // rgb_panel_input_port

// ---- dv/panel_checker.sv ----
// panel_checker: port-level properties of the panel input port
// assumes: bound onto rgb_panel_input_port, one clock domain
`timescale 1ns/1ps
module panel_checker
  import panel_pkg::*;
#(
  parameter int COLS = 16,
  parameter int LINES = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pixelClockPin,
  input wire logic scanInvertSelectPin,
  input wire logic pixelValid,
  input wire logic pixelReady,
  input wire pixel_word_t pixelWord,
  input wire logic overflow
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic pinPrev;
  logic [4:0] sinceEdge;
  logic [COL_W-1:0] lastCol;
  // saturating age of the last pin edge, so long idle gaps cannot wrap
  always_ff @(posedge clock) begin
    pinPrev <= pixelClockPin;
    if (rst) sinceEdge <= 5'h1f;
    else if (pixelClockPin && !pinPrev) sinceEdge <= 5'h00;
    else if (sinceEdge != 5'h1f) sinceEdge <= sinceEdge + 5'h01;
    if (pixelValid && pixelReady) lastCol <= pixelWord.col;
  end
  a_word_holds: assert property (pixelValid && !pixelReady |=> pixelValid && $stable(pixelWord))
    else $error("pending word changed");
  a_overflow_sticky: assert property (overflow |=> overflow)
    else $error("overflow dropped");
  a_col_range: assert property (pixelValid |-> pixelWord.col < COLS)
    else $error("column out of area");
  a_row_range: assert property (pixelValid |-> pixelWord.row < LINES)
    else $error("row out of area");
  a_frame_origin: assert property (pixelValid && pixelWord.frameStart |-> (scanInvertSelectPin ?
    pixelWord.col == COLS - 1 && pixelWord.row == LINES - 1 : pixelWord.col == 0 && pixelWord.row == 0))
    else $error("frame origin misplaced");
  a_pixel_paced: assert property ($rose(pixelValid) |-> sinceEdge <= 5'h08)
    else $error("pixel without clock edge");
  a_col_step: assert property (pixelValid && pixelReady && !scanInvertSelectPin && !overflow
    && pixelWord.col != 0 |-> pixelWord.col == lastCol + 1) else $error("column skipped");
  a_overflow_cause: assert property ($rose(overflow) |-> $past(pixelValid) && !$past(pixelReady))
    else $error("overflow without full buffer");
endmodule // panel_checker

bind rgb_panel_input_port panel_checker #(.COLS(COLS), .LINES(LINES)) chkr (.clock, .rst, .pixelClockPin,
  .scanInvertSelectPin, .pixelValid, .pixelReady, .pixelWord, .overflow);

// ---- dv/video_source.sv ----
// video_source: display controller model driving parallel rgb timing
// assumes: frames requested by task call; pixel clock parked low between frames
`timescale 1ns/1ps
module video_source
  import panel_pkg::*;
#(
  parameter int COLS = 16,
  parameter int NLINES = 13,
  parameter int LINE_PIX = 90
) (
  input wire logic clock,
  output logic pixelClockPin,
  output logic hSyncPin,
  output logic vSyncPin,
  output logic lineDataEnablePin,
  output logic [COMP_W-1:0] redComponent,
  output logic [COMP_W-1:0] greenComponent,
  output logic [COMP_W-1:0] blueComponent
);
  // ----------------------------------------
  // pixel and frame generation
  // ----------------------------------------
  initial {pixelClockPin, hSyncPin, vSyncPin, lineDataEnablePin, redComponent, greenComponent, blueComponent} = '0;
  // pins change while the pixel clock is low and hold across its rising edge
  task automatic pix(input logic hs, input logic vs, input logic en, input logic [5:0] r, input logic [5:0] g);
    @(posedge clock);
    {hSyncPin, vSyncPin, lineDataEnablePin} <= {hs, vs, en};
    {redComponent, greenComponent, blueComponent} <= {r, g, 6'h15};
    repeat (4) @(posedge clock);
    pixelClockPin <= 1'b1;
    repeat (5) @(posedge clock);
    pixelClockPin <= 1'b0;
  endtask
  task automatic send_frame(input bit en);
    int s;
    // fixed start: column 0 is the pixel FIXED_H_START clocks after the sync-rise pixel
    s = en ? 10 : FIXED_H_START;
    for (int p = 0; p < LINE_PIX; p++) pix(1'b0, 1'b1, 1'b0, 6'h00, 6'h00);
    for (int l = 1; l <= NLINES; l++)
      for (int p = 0; p < LINE_PIX; p++)
        pix(p < 2, 1'b0, en && p >= s && p < s + COLS, 6'(p - s), 6'(l));
    // released data shows the inverse, never a frozen last pixel
    @(posedge clock);
    {redComponent, greenComponent, blueComponent} <= ~{redComponent, greenComponent, blueComponent};
  endtask
endmodule // video_source

// ---- dv/tb.sv ----
// tb: frames from the controller model through the port into a checking sink
// assumes: 50 MHz clock, active area reduced to 16 by 8
`timescale 1ns/1ps
module tb
  import panel_pkg::*;
;
  localparam int COLS = 16;
  localparam int LINES = 8;
  localparam int CW = $bits(pixel_word_t);
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pixelReady = 1'b0;
  logic scanInvertSelectPin = 1'b0;
  logic chk = 1'b1;
  logic pixelClockPin, hSyncPin, vSyncPin, lineDataEnablePin, pixelValid, overflow;
  logic [COMP_W-1:0] redComponent, greenComponent, blueComponent;
  logic [1:0] rdyMode = 2'd1;
  logic [1:0] cyc = 2'd0;
  pixel_word_t pixelWord, e;
  int n_fail = 0, comparisons = 0, k = 0, r, c;
  always #10 clock = ~clock;
  video_source #(.COLS(COLS)) src (.clock, .pixelClockPin, .hSyncPin, .vSyncPin, .lineDataEnablePin,
    .redComponent, .greenComponent, .blueComponent);
  rgb_panel_input_port #(.COLS(COLS), .LINES(LINES)) dut (.clock, .rst, .pixelClockPin, .hSyncPin, .vSyncPin,
    .lineDataEnablePin, .scanInvertSelectPin, .redComponent, .greenComponent, .blueComponent, .pixelValid,
    .pixelReady, .pixelWord, .overflow);
  // ----------------------------------------
  // sink and scoreboard
  // ----------------------------------------
  task automatic check(input logic [CW-1:0] seen, input logic [CW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // the source cannot be held off, so stalls are short except in the loss test
  always @(posedge clock) begin
    cyc <= cyc + 2'd1;
    pixelReady <= rdyMode == 2'd2 ? cyc == 2'd0 : rdyMode == 2'd1;
    if (chk && pixelValid === 1'b1 && pixelReady === 1'b1) begin
      r = k / COLS;
      c = k % COLS;
      e.col = COL_W'(scanInvertSelectPin ? COLS - 1 - c : c);
      e.row = LINE_W'(scanInvertSelectPin ? LINES - 1 - r : r);
      e.frameStart = k == 0;
      e.pix = {6'(c), 6'(r + V_START), 6'h15};
      check(pixelWord, e);
      k++;
    end
  end
  task automatic run_frame(input bit en, input bit iv, input logic [1:0] mode);
    scanInvertSelectPin <= iv;
    rdyMode <= mode;
    k = 0;
    src.send_frame(en);
    for (int i = 0; i < 60 && pixelValid !== 1'b0; i++) @(posedge clock);
    check(CW'(k), CW'(COLS * LINES));
    check(CW'(overflow), CW'(0));
  endtask
  task automatic test_strobe_normal();
    run_frame(1'b1, 1'b0, 2'd1);
    $display("test_strobe_normal done");
  endtask
  task automatic test_strobe_mirror();
    run_frame(1'b1, 1'b1, 2'd1);
    $display("test_strobe_mirror done");
  endtask
  task automatic test_fixed_stall();
    run_frame(1'b0, 1'b0, 2'd2);
    $display("test_fixed_stall done");
  endtask
  task automatic test_overflow();
    chk = 1'b0;
    rdyMode <= 2'd0;
    src.send_frame(1'b1);
    check(CW'(overflow), CW'(1));
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(CW'({overflow, pixelValid}), CW'(0));
    $display("test_overflow done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    test_strobe_normal();
    test_strobe_mirror();
    test_fixed_stall();
    test_overflow();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule // tb
